// File: bridge_regs_pkg.sv
// constants for the bridge window, doorbell and dma register block
`default_nettype none
package bridge_regs_pkg;
  localparam logic [7:0] OFF_DMA_CTRL = 8'h28;
  localparam logic [7:0] OFF_IN_MEM_BASES = 8'h2c;
  localparam logic [7:0] OFF_IN_IO_BASE = 8'h30;
  localparam logic [7:0] OFF_OUT_MEM_BASES = 8'h34;
  localparam logic [7:0] OFF_IN_BELL = 8'h38;
  localparam logic [7:0] OFF_OUT_BELL = 8'h3c;
  localparam logic [7:0] OFF_BUF0_SRC = 8'h40;
  localparam logic [7:0] OFF_BUF0_DST = 8'h44;
  localparam logic [7:0] OFF_BUF1_SRC = 8'h4c;
  localparam logic [7:0] OFF_BUF1_DST = 8'h50;
  localparam logic [31:0] RST_IN_MEM_BASES = 32'hc0000000;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam int BIT_OUT_IRQ_EN = 0;
  localparam int BIT_BUF0_DONE = 4;
  localparam int BIT_BUF0_ERR = 5;
  localparam int BIT_BUF1_DONE = 6;
  localparam int BIT_BUF1_ERR = 7;
  localparam int BIT_IN_IRQ_EN = 8;
  localparam int IO_BASE_W = 24;
  localparam int WIN_LOW_W = 24;
  localparam int IO_LOW_W = 8;
endpackage
`default_nettype wire

// File: bell_reg.sv
// one doorbell register: set from one side, clear from the other, test mode
`default_nettype none
module bell_reg
  import bridge_regs_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic test_mode,
  input wire logic set_we,
  input wire logic [WIDTH-1:0] set_data,
  input wire logic clr_we,
  input wire logic [WIDTH-1:0] clr_data,
  input wire logic load_we,
  input wire logic [WIDTH-1:0] load_data,
  output logic [WIDTH-1:0] bits_reg,
  output logic any_reg
);
  logic [WIDTH-1:0] bits_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("bell_reg width must be positive");
  end

  always_comb begin
    bits_next = bits_reg;
    if (test_mode && load_we) begin
      bits_next = load_data;
    end else begin
      if (clr_we && !test_mode) bits_next = bits_next & ~clr_data;
      // a set arriving with a clear wins
      if (set_we) bits_next = bits_next | set_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bits_reg <= '0;
      any_reg <= 1'b0;
    end else begin
      bits_reg <= bits_next;
      any_reg <= |bits_next;
    end
  end
endmodule
`default_nettype wire

// File: bridge_window_bell.sv
// bridge register block: windows, doorbells, dma control and addresses
`default_nettype none
module bridge_window_bell
  import bridge_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  // ahb-side register port
  input wire logic ahb_wr,
  input wire logic ahb_rd,
  input wire logic [7:0] ahb_addr,
  input wire logic [31:0] ahb_wdata,
  output logic [31:0] ahb_rdata,
  // pci-side register port
  input wire logic pci_wr,
  input wire logic pci_rd,
  input wire logic [7:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  output logic [31:0] pci_rdata,
  // controller control bits
  input wire logic bell_test_mode,
  input wire logic pci_bell_irq_en,
  // dma engine events
  input wire logic buf0_end,
  input wire logic buf0_fail,
  input wire logic buf1_end,
  input wire logic buf1_fail,
  output logic chan_en_clear,
  // inbound translation
  input wire logic [1:0] in_win_sel,
  input wire logic [31:0] in_pci_addr,
  output logic [31:0] in_mem_ahb_addr,
  output logic [31:0] in_io_ahb_addr,
  // outbound translation
  input wire logic [31:0] out_ahb_addr,
  output logic [31:0] out_pci_addr,
  // interrupts and status
  output logic pci_inta_n,
  output logic outdma_done_irq,
  output logic indma_done_irq_en,
  output logic inbound_bell_stat,
  output logic outbound_bell_stat,
  // dma addresses to the engine
  output logic [31:0] buf0_src,
  output logic [31:0] buf0_dst,
  output logic [31:0] buf1_src,
  output logic [31:0] buf1_dst
);
  logic [31:0] inbound_mem_window_bases_reg;
  logic [IO_BASE_W-1:0] inbound_io_upper_reg;
  logic [31:0] outbound_mem_partition_bases_reg;
  logic [29:0] buf0_src_reg, buf0_dst_reg, buf1_src_reg, buf1_dst_reg;
  logic outdma_done_irq_en;
  logic indma_en_reg;
  logic outdma_buf0_done, outdma_buf0_err;
  logic outdma_buf1_done, outdma_buf1_err;
  logic [31:0] inbound_bell_bits, outbound_bell_bits;
  logic in_any, out_any;
  logic test_meta, test_sync;
  logic [31:0] dma_ctrl_view;

  // select byte field n (0 = top byte) of a packed base word
  function automatic logic [7:0] base_field(input logic [31:0] w,
                                            input logic [1:0] n);
    case (n)
      2'd0: base_field = w[31:24];
      2'd1: base_field = w[23:16];
      2'd2: base_field = w[15:8];
      default: base_field = w[7:0];
    endcase
  endfunction

  function automatic logic ahb_hit(input logic [7:0] off);
    ahb_hit = ahb_wr && (ahb_addr == off);
  endfunction

  // test mode comes from another block's register; synchronised anyway
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      test_meta <= 1'b0;
      test_sync <= 1'b0;
    end else begin
      test_meta <= bell_test_mode;
      test_sync <= test_meta;
    end
  end

  // translation bases, ahb writes only; pci writes are ignored
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inbound_mem_window_bases_reg <= RST_IN_MEM_BASES;
      inbound_io_upper_reg <= '0;
      outbound_mem_partition_bases_reg <= RST_ZERO;
    end else begin
      if (ahb_hit(OFF_IN_MEM_BASES))
        inbound_mem_window_bases_reg <= ahb_wdata;
      if (ahb_hit(OFF_IN_IO_BASE))
        inbound_io_upper_reg <= ahb_wdata[IO_BASE_W-1:0];
      if (ahb_hit(OFF_OUT_MEM_BASES))
        outbound_mem_partition_bases_reg <= ahb_wdata;
    end
  end

  // dma address pairs hold word addresses only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      buf0_src_reg <= '0;
      buf0_dst_reg <= '0;
      buf1_src_reg <= '0;
      buf1_dst_reg <= '0;
    end else begin
      if (ahb_hit(OFF_BUF0_SRC)) buf0_src_reg <= ahb_wdata[31:2];
      if (ahb_hit(OFF_BUF0_DST)) buf0_dst_reg <= ahb_wdata[31:2];
      if (ahb_hit(OFF_BUF1_SRC)) buf1_src_reg <= ahb_wdata[31:2];
      if (ahb_hit(OFF_BUF1_DST)) buf1_dst_reg <= ahb_wdata[31:2];
    end
  end

  // dma control: enables and sticky done/error flags; set beats clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      outdma_done_irq_en <= 1'b0;
      indma_en_reg <= 1'b0;
      outdma_buf0_done <= 1'b0;
      outdma_buf0_err <= 1'b0;
      outdma_buf1_done <= 1'b0;
      outdma_buf1_err <= 1'b0;
    end else begin
      if (ahb_hit(OFF_DMA_CTRL)) begin
        outdma_done_irq_en <= ahb_wdata[BIT_OUT_IRQ_EN];
        indma_en_reg <= ahb_wdata[BIT_IN_IRQ_EN];
        if (ahb_wdata[BIT_BUF0_DONE]) begin
          outdma_buf0_done <= 1'b0;
          outdma_buf0_err <= 1'b0;
        end
        if (ahb_wdata[BIT_BUF1_DONE]) begin
          outdma_buf1_done <= 1'b0;
          outdma_buf1_err <= 1'b0;
        end
      end
      if (buf0_end || buf0_fail) outdma_buf0_done <= 1'b1;
      if (buf0_fail) outdma_buf0_err <= 1'b1;
      if (buf1_end || buf1_fail) outdma_buf1_done <= 1'b1;
      if (buf1_fail) outdma_buf1_err <= 1'b1;
    end
  end

  // bell strobes decoded as nets: a function call in a port expression
  // would not follow the bus signals that the function reads
  logic ahb_in_bell_we, ahb_out_bell_we;
  assign ahb_in_bell_we = ahb_wr && (ahb_addr == OFF_IN_BELL);
  assign ahb_out_bell_we = ahb_wr && (ahb_addr == OFF_OUT_BELL);

  // inbound bell: pci sets, ahb clears (or loads in test mode)
  bell_reg #(.WIDTH(32)) in_bell (
    .sys_clk(sys_clk),
    .reset(reset),
    .test_mode(test_sync),
    .set_we(pci_wr && (pci_addr == OFF_IN_BELL)),
    .set_data(pci_wdata),
    .clr_we(ahb_in_bell_we),
    .clr_data(ahb_wdata),
    .load_we(ahb_in_bell_we),
    .load_data(ahb_wdata),
    .bits_reg(inbound_bell_bits),
    .any_reg(in_any)
  );

  // outbound bell: ahb sets (or loads in test mode), pci clears outside test mode only
  logic [31:0] out_clr_data;
  logic out_clr_we;
  assign out_clr_we = pci_wr && (pci_addr == OFF_OUT_BELL);
  assign out_clr_data = pci_wdata;
  bell_reg #(.WIDTH(32)) out_bell (
    .sys_clk(sys_clk),
    .reset(reset),
    .test_mode(test_sync),
    .set_we(ahb_out_bell_we && !test_sync),
    .set_data(ahb_wdata),
    .clr_we(out_clr_we),
    .clr_data(out_clr_data),
    .load_we(ahb_out_bell_we),
    .load_data(ahb_wdata),
    .bits_reg(outbound_bell_bits),
    .any_reg(out_any)
  );

  assign dma_ctrl_view = {23'h0, indma_en_reg, outdma_buf1_err,
                          outdma_buf1_done, outdma_buf0_err,
                          outdma_buf0_done, 3'h0, outdma_done_irq_en};

  // shared read mux; unmapped offsets read zero
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    if (a == OFF_DMA_CTRL) read_mux = dma_ctrl_view;
    else if (a == OFF_IN_MEM_BASES) read_mux = inbound_mem_window_bases_reg;
    else if (a == OFF_IN_IO_BASE)
      read_mux = {8'h00, inbound_io_upper_reg};
    else if (a == OFF_OUT_MEM_BASES)
      read_mux = outbound_mem_partition_bases_reg;
    else if (a == OFF_IN_BELL) read_mux = inbound_bell_bits;
    else if (a == OFF_OUT_BELL) read_mux = outbound_bell_bits;
    else if (a == OFF_BUF0_SRC) read_mux = {buf0_src_reg, 2'b00};
    else if (a == OFF_BUF0_DST) read_mux = {buf0_dst_reg, 2'b00};
    else if (a == OFF_BUF1_SRC) read_mux = {buf1_src_reg, 2'b00};
    else if (a == OFF_BUF1_DST) read_mux = {buf1_dst_reg, 2'b00};
    else read_mux = 32'h00000000;
  endfunction

  // read data stands one cycle and is zero otherwise
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ahb_rdata <= '0;
    end else begin
      ahb_rdata <= ahb_rd ? read_mux(ahb_addr) : 32'h00000000;
    end
  end

  // pci reads see the same map; pci writes only ever reach the bells
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pci_rdata <= '0;
    end else begin
      pci_rdata <= pci_rd ? read_mux(pci_addr) : 32'h00000000;
    end
  end

  // address translation, registered
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      in_mem_ahb_addr <= '0;
      in_io_ahb_addr <= '0;
      out_pci_addr <= '0;
    end else begin
      in_mem_ahb_addr <= {base_field(inbound_mem_window_bases_reg,
                          in_win_sel), in_pci_addr[WIN_LOW_W-1:0]};
      in_io_ahb_addr <= {inbound_io_upper_reg,
                         in_pci_addr[IO_LOW_W-1:0]};
      out_pci_addr <= {base_field(outbound_mem_partition_bases_reg,
                       out_ahb_addr[25:24]),
                       out_ahb_addr[WIN_LOW_W-1:0]};
    end
  end

  // interrupt outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pci_inta_n <= 1'b1;
      outdma_done_irq <= 1'b0;
      indma_done_irq_en <= 1'b0;
    end else begin
      pci_inta_n <= !(out_any && pci_bell_irq_en);
      outdma_done_irq <= outdma_done_irq_en &&
                         (outdma_buf0_done || outdma_buf1_done);
      indma_done_irq_en <= indma_en_reg;
    end
  end

  // bell status levels, same latency as the pci interrupt
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inbound_bell_stat <= 1'b0;
      outbound_bell_stat <= 1'b0;
    end else begin
      inbound_bell_stat <= in_any;
      outbound_bell_stat <= out_any;
    end
  end

  // one-cycle pulse telling the engine to drop the channel enable
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chan_en_clear <= 1'b0;
    end else begin
      chan_en_clear <= buf0_end || buf0_fail || buf1_end || buf1_fail;
    end
  end

  assign buf0_src = {buf0_src_reg, 2'b00};
  assign buf0_dst = {buf0_dst_reg, 2'b00};
  assign buf1_src = {buf1_src_reg, 2'b00};
  assign buf1_dst = {buf1_dst_reg, 2'b00};
endmodule
`default_nettype wire

// File: bridge_window_bell_properties.sv
// port checker for the bridge register block
`default_nettype none
module bridge_window_bell_properties
  import bridge_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ahb_wr,
  input wire logic [7:0] ahb_addr,
  input wire logic [31:0] ahb_wdata,
  input wire logic pci_bell_irq_en,
  input wire logic buf0_end,
  input wire logic buf0_fail,
  input wire logic buf1_end,
  input wire logic buf1_fail,
  input wire logic chan_en_clear,
  input wire logic pci_inta_n,
  input wire logic outbound_bell_stat,
  input wire logic [31:0] in_pci_addr,
  input wire logic [31:0] in_mem_ahb_addr,
  input wire logic [31:0] in_io_ahb_addr,
  input wire logic [31:0] out_ahb_addr,
  input wire logic [31:0] out_pci_addr,
  input wire logic [31:0] buf0_src,
  input wire logic [31:0] buf0_dst,
  input wire logic [31:0] buf1_src,
  input wire logic [31:0] buf1_dst
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic ev = buf0_end | buf0_fail | buf1_end | buf1_fail;
  a_evt_clear: assert property (ev |=> chan_en_clear)
    else $error("channel clear pulse missing");
  a_clear_cause: assert property (chan_en_clear |-> $past(ev))
    else $error("channel clear without an event");
  a_bell_irq: assert property (outbound_bell_stat &&
    $past(pci_bell_irq_en) |-> !pci_inta_n)
    else $error("pci interrupt not driven");
  a_irq_quiet: assert property (!(outbound_bell_stat &&
    $past(pci_bell_irq_en)) |-> pci_inta_n)
    else $error("pci interrupt without cause");
  a_mem_xlate: assert property (!$past(reset) |->
    in_mem_ahb_addr[23:0] == $past(in_pci_addr[23:0]))
    else $error("memory window low bits wrong");
  a_io_xlate: assert property (!$past(reset) |->
    in_io_ahb_addr[7:0] == $past(in_pci_addr[7:0]))
    else $error("io window low bits wrong");
  a_out_xlate: assert property (!$past(reset) |->
    out_pci_addr[23:0] == $past(out_ahb_addr[23:0]))
    else $error("partition low bits wrong");
  a_src_word: assert property (ahb_wr && ahb_addr == OFF_BUF0_SRC
    |=> buf0_src == ($past(ahb_wdata) & 32'hfffffffc))
    else $error("dma source address wrong");
  a_dst_word: assert property (ahb_wr && ahb_addr == OFF_BUF0_DST
    |=> buf0_dst == ($past(ahb_wdata) & 32'hfffffffc))
    else $error("dma destination address wrong");
  c_event: cover property (ev);
  c_irq: cover property (!pci_inta_n);
  c_bell: cover property (outbound_bell_stat);
endmodule
bind bridge_window_bell bridge_window_bell_properties i_props (.*);
`default_nettype wire

// File: pci_agent_model.sv
// pci-side agent: rings and clears doorbells through the pci register port
`default_nettype none
module pci_agent_model (
  input wire logic sys_clk,
  output logic pci_wr,
  output logic pci_rd,
  output logic [7:0] pci_addr,
  output logic [31:0] pci_wdata,
  input wire logic [31:0] pci_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pci_wr = 1'b0;
    pci_rd = 1'b0;
    pci_addr = 8'h00;
    pci_wdata = 32'h00000000;
  end
  // released lines show the inverse so stale data never passes as valid
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1 pci_wr = 1'b1;
    pci_addr = a;
    pci_wdata = d;
    @(posedge sys_clk);
    #1 pci_wr = 1'b0;
    pci_addr = ~a;
    pci_wdata = ~d;
  endtask
  // read data is taken while it stands, one cycle after the strobe edge
  task automatic get(input logic [7:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    #1 pci_rd = 1'b1;
    pci_addr = a;
    @(posedge sys_clk);
    #1 pci_rd = 1'b0;
    q = pci_rdata;
    pci_addr = ~a;
  endtask
endmodule
`default_nettype wire

// File: test_bridge_window_bell.sv
// self-checking bench for the bridge register block
`default_nettype none
module test_bridge_window_bell;
  timeunit 1ns;
  timeprecision 100ps;
  import bridge_regs_pkg::*;
  logic sys_clk = 0, reset = 1, ahb_wr = 0, ahb_rd = 0;
  logic pci_wr, pci_rd, bell_test_mode = 0, pci_bell_irq_en = 0;
  logic buf0_end = 0, buf0_fail = 0, buf1_end = 0, buf1_fail = 0;
  logic chan_en_clear, pci_inta_n, outdma_done_irq, indma_done_irq_en;
  logic inbound_bell_stat, outbound_bell_stat;
  logic [1:0] in_win_sel = 0;
  logic [7:0] ahb_addr = 0, pci_addr;
  logic [31:0] ahb_wdata = 0, ahb_rdata, pci_rdata, pci_wdata;
  logic [31:0] in_pci_addr = 0, out_ahb_addr = 0, in_mem_ahb_addr;
  logic [31:0] in_io_ahb_addr, out_pci_addr, buf0_src, buf0_dst;
  logic [31:0] buf1_src, buf1_dst, bases, io, parts, d, seen;
  logic [7:0] aofs[4] = '{OFF_BUF0_SRC, OFF_BUF0_DST, OFF_BUF1_SRC,
    OFF_BUF1_DST};
  int err_total = 0, samples_checked = 0;
  bridge_window_bell i_bridge_window_bell (.*);
  pci_agent_model i_pci_agent_model (.*);
  always #4 sys_clk = ~sys_clk;
  function automatic logic [31:0] win(input logic [31:0] b,
    input logic [1:0] s, input logic [31:0] a);
    return {b[8*(3-s) +: 8], a[23:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    #1 ahb_wr = 1'b1;
    ahb_addr = a;
    ahb_wdata = v;
    @(posedge sys_clk);
    #1 ahb_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    #1 ahb_rd = 1'b1;
    ahb_addr = a;
    @(posedge sys_clk);
    #1 ahb_rd = 1'b0;
    check(ahb_rdata, e);
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge sys_clk);
    #1 {buf1_fail, buf1_end, buf0_fail, buf0_end} = m;
    @(posedge sys_clk);
    #1 {buf1_fail, buf1_end, buf0_fail, buf0_end} = 4'h0;
    check({31'h0, chan_en_clear}, 32'h1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    test_done;
  end
  initial begin
    d = $urandom(32'h974f);
    repeat (12) @(posedge sys_clk);
    #1 reset = 0;
    check({31'h0, pci_inta_n}, 32'h1);
    // 0x48 lies outside this block and must read as zero
    for (int i = 8'h28; i <= 8'h50; i += 4)
      rd(i[7:0], i == 8'h2c ? RST_IN_MEM_BASES : RST_ZERO);
    bases = $urandom;
    io = $urandom;
    parts = $urandom;
    d = $urandom;
    wr(OFF_IN_MEM_BASES, bases);
    wr(OFF_IN_IO_BASE, io);
    wr(OFF_OUT_MEM_BASES, parts);
    i_pci_agent_model.put(OFF_IN_MEM_BASES, ~bases);
    rd(OFF_IN_MEM_BASES, bases);
    i_pci_agent_model.get(OFF_IN_MEM_BASES, seen);
    check(seen, bases);
    rd(OFF_IN_IO_BASE, {8'h00, io[23:0]});
    rd(OFF_OUT_MEM_BASES, parts);
    foreach (aofs[i]) begin
      wr(aofs[i], d + i);
      rd(aofs[i], (d + i) & 32'hfffffffc);
    end
    check(buf1_dst, (d + 3) & 32'hfffffffc);
    check(buf0_src, d & 32'hfffffffc);
    check(buf0_dst, (d + 1) & 32'hfffffffc);
    check(buf1_src, (d + 2) & 32'hfffffffc);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      #1 in_win_sel = s[1:0];
      in_pci_addr = $urandom;
      out_ahb_addr = $urandom;
      out_ahb_addr[25:24] = s[1:0];
      @(posedge sys_clk);
      #1 check(in_mem_ahb_addr, win(bases, s[1:0], in_pci_addr));
      check(in_io_ahb_addr, {io[23:0], in_pci_addr[7:0]});
      check(out_pci_addr, win(parts, s[1:0], out_ahb_addr));
    end
    pci_bell_irq_en = 1;
    wr(OFF_OUT_BELL, 32'h80000001);
    wr(OFF_OUT_BELL, 32'h00000100);
    rd(OFF_OUT_BELL, 32'h80000101);
    check({31'h0, outbound_bell_stat}, 32'h1);
    check({31'h0, pci_inta_n}, 32'h0);
    i_pci_agent_model.put(OFF_OUT_BELL, 32'h80000001);
    rd(OFF_OUT_BELL, 32'h00000100);
    i_pci_agent_model.put(OFF_OUT_BELL, 32'h00000100);
    rd(OFF_OUT_BELL, 32'h0);
    check({31'h0, pci_inta_n, outbound_bell_stat}, 32'h2);
    i_pci_agent_model.put(OFF_IN_BELL, d);
    i_pci_agent_model.put(OFF_IN_BELL, 32'h1);
    rd(OFF_IN_BELL, d | 1);
    i_pci_agent_model.get(OFF_IN_BELL, seen);
    check(seen, d | 1);
    check({31'h0, inbound_bell_stat}, 32'h1);
    wr(OFF_IN_BELL, d);
    rd(OFF_IN_BELL, (d | 1) & ~d);
    wr(OFF_IN_BELL, 32'hffffffff);
    rd(OFF_IN_BELL, 32'h0);
    check({31'h0, inbound_bell_stat}, 32'h0);
    bell_test_mode = 1;
    wr(OFF_IN_BELL, 32'hff);
    wr(OFF_IN_BELL, 32'h5a);
    rd(OFF_IN_BELL, 32'h5a);
    wr(OFF_OUT_BELL, 32'h3c);
    wr(OFF_OUT_BELL, 32'h0);
    rd(OFF_OUT_BELL, 32'h0);
    bell_test_mode = 0;
    wr(OFF_DMA_CTRL, 32'h0000010f);
    rd(OFF_DMA_CTRL, 32'h101);
    check({31'h0, indma_done_irq_en}, 32'h1);
    ev(4'b0010);
    ev(4'b0100);
    rd(OFF_DMA_CTRL, 32'h171);
    check({31'h0, outdma_done_irq}, 32'h1);
    wr(OFF_DMA_CTRL, 32'h111);
    ev(4'b1000);
    rd(OFF_DMA_CTRL, 32'h1c1);
    wr(OFF_DMA_CTRL, 32'h141);
    rd(OFF_DMA_CTRL, 32'h101);
    check({31'h0, outdma_done_irq}, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
